// file: rtl/acw_pkg.sv
/*
  Constants for the adapter control word block: bit positions, reset
  values and network-select encodings.
  Assumes a 16-bit host access port to the control word.
*/
package acw_pkg;

  localparam int unsigned WORD_W        = 16;
  // Bit positions inside the control word
  localparam int unsigned BIT_TYPE_A    = 0;
  localparam int unsigned BIT_TYPE_B    = 2;
  localparam int unsigned BIT_HOLD_ACK  = 4;
  localparam int unsigned BIT_DIR       = 5;
  localparam int unsigned BIT_REQ_VIEW  = 6;
  localparam int unsigned BIT_PDMA_EN   = 7;
  localparam int unsigned BIT_HOLD_RST  = 8;
  localparam int unsigned BIT_IRQ_EN    = 12;
  localparam int unsigned BIT_PARITY    = 13;
  localparam int unsigned BIT_NSEL_A    = 14;
  localparam int unsigned BIT_NSEL_B    = 15;
  // Writable storage bits outside the special ones
  localparam logic [15:0] PLAIN_MASK    = 16'h0e00;
  // Values after reset
  localparam logic        RST_HOLD      = 1'b1;
  localparam logic        RST_IRQ_EN    = 1'b0;
  localparam logic        RST_PDMA_EN   = 1'b0;
  localparam logic        RST_HOLD_ACK  = 1'b0;
  localparam logic [1:0]  RST_NSEL      = 2'h0;
  localparam logic [2:0]  RST_PLAIN     = 3'h0;
  // Registered read word after reset: only the hold bit reads as set
  localparam logic [15:0] RST_RD_WORD   = 16'(RST_HOLD) << BIT_HOLD_RST;
  // Network-select pair encodings {b,a}
  localparam logic [1:0]  NSEL_LOW_SPD  = 2'h3;
  localparam logic [1:0]  NSEL_HIGH_SPD = 2'h2;

  typedef enum logic [1:0] {ACW_NET_RSVD, ACW_NET_HIGH, ACW_NET_LOW} acw_net_e;

endpackage

// file: rtl/acw_store.sv
/*
  Small holding register for the plain writable bits (9..11) of the
  control word; read data comes from a register.
  Assumes write strobe and data synchronous to core_clk_i.
*/
`timescale 1ns/1ps
module acw_store (
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       wr_en_i,
  input  wire logic [2:0] wr_data_i,
  output logic      [2:0] rd_data_o
);

  logic [2:0] mem_d;
  logic [2:0] mem_q;

  always_comb
  begin
    mem_d = wr_en_i ? wr_data_i : mem_q;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      mem_q <= acw_pkg::RST_PLAIN;
    else
      mem_q <= mem_d;
  end

  assign rd_data_o = mem_q;

endmodule

// file: rtl/acw_ctrl.sv
/*
  The whole host-visible adapter control word, bits 0 to 15: interrupt gating
  with pseudo-DMA, parity enable, network select and hold reset, plus
  network-type mirrors and the wire-fault output.
  Assumes strap and pin inputs synchronous to core_clk_i and a single
  host write/read port on the same clock.
*/
`timescale 1ns/1ps
module acw_ctrl (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        wr_en_i,
  input  wire logic [15:0] wr_data_i,
  output logic      [15:0] rd_data_o,
  input  wire logic        sys_irq_i,
  input  wire logic        pdma_req_i,
  input  wire logic        pdma_dir_i,
  input  wire logic        net_type_pin_a_i,
  input  wire logic        net_type_pin_b_i,
  input  wire logic        parity_default_strap_i,
  input  wire logic        fault_a_i,
  input  wire logic        fault_b_i,
  input  wire logic        clock_fail_i,
  output logic             host_irq_out_o,
  output logic             pdma_active_o,
  output logic             parity_check_enable_o,
  output logic             net_select_out_a_o,
  output logic             net_select_out_b_o,
  output logic             low_speed_mode_o,
  output logic             core_reset_o,
  output logic             wire_fault_n_o
);

  function automatic acw_pkg::acw_net_e decode_net(input logic [1:0] sel);
    acw_pkg::acw_net_e n;
    n = acw_pkg::ACW_NET_RSVD;
    if (sel == acw_pkg::NSEL_LOW_SPD)
      n = acw_pkg::ACW_NET_LOW;
    else if (sel == acw_pkg::NSEL_HIGH_SPD)
      n = acw_pkg::ACW_NET_HIGH;
    return n;
  endfunction

  logic       hold_d,    hold_q;
  logic       irq_en_d,  irq_en_q;
  logic       pdma_en_d, pdma_en_q;
  logic       ack_d,     ack_q;
  logic       par_d,     par_q;
  logic       par_init_q;
  logic [1:0] nsel_d,    nsel_q;
  logic       irq_d,     irq_q;
  logic       act_d,     act_q;
  logic       low_d,     low_q;
  logic       wire_fault_n_d,    wire_fault_n_q;
  logic [2:0] plain_rd;
  logic [15:0] rd_d;
  logic [15:0] rd_q;

  acw_store u_store (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .wr_en_i    (wr_en_i),
    .wr_data_i  (wr_data_i[11:9]),
    .rd_data_o  (plain_rd)
  );

  // Control word state
  always_comb
  begin
    // A clock failure forces the hold bit and wins over a write clearing it
    hold_d    = hold_q | clock_fail_i;
    irq_en_d  = irq_en_q;
    pdma_en_d = pdma_en_q;
    ack_d     = ack_q;
    par_d     = par_q;
    if (wr_en_i)
    begin
      hold_d    = wr_data_i[acw_pkg::BIT_HOLD_RST] | clock_fail_i;
      irq_en_d  = wr_data_i[acw_pkg::BIT_IRQ_EN];
      pdma_en_d = wr_data_i[acw_pkg::BIT_PDMA_EN];
      ack_d     = wr_data_i[acw_pkg::BIT_HOLD_ACK] & wr_data_i[acw_pkg::BIT_PDMA_EN];
      par_d     = wr_data_i[acw_pkg::BIT_PARITY];
    end
    // Parity default follows strap once after reset release; a write landing on
    // that very edge loses, since the strap sets the power-on choice
    if (!par_init_q)
      par_d = parity_default_strap_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hold_q     <= acw_pkg::RST_HOLD;
      irq_en_q   <= acw_pkg::RST_IRQ_EN;
      pdma_en_q  <= acw_pkg::RST_PDMA_EN;
      ack_q      <= acw_pkg::RST_HOLD_ACK;
      par_q      <= 1'b0;
      par_init_q <= 1'b0;
    end
    else
    begin
      hold_q     <= hold_d;
      irq_en_q   <= irq_en_d;
      pdma_en_q  <= pdma_en_d;
      ack_q      <= ack_d;
      par_q      <= par_d;
      par_init_q <= 1'b1;
    end
  end

  // Select pair: only a write made while the core is held may change it, so
  // the ring side never sees its speed move under a running core
  always_comb
  begin
    nsel_d = nsel_q;
    if (wr_en_i && hold_q)
    begin
      nsel_d = {wr_data_i[acw_pkg::BIT_NSEL_B], wr_data_i[acw_pkg::BIT_NSEL_A]};
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      nsel_q <= acw_pkg::RST_NSEL;
    else
      nsel_q <= nsel_d;
  end

  // Output stage; one cycle behind the control word and inputs
  always_comb
  begin
    act_d  = pdma_en_q & pdma_req_i & ack_q;
    irq_d  = (pdma_en_q & pdma_req_i & ~ack_q)
           | (irq_en_q & sys_irq_i);
    low_d  = (decode_net(nsel_q) == acw_pkg::ACW_NET_LOW);
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      irq_q  <= 1'b0;
      act_q  <= 1'b0;
      low_q  <= 1'b0;
    end
    else
    begin
      irq_q  <= irq_d;
      act_q  <= act_d;
      low_q  <= low_d;
    end
  end

  // Wire fault is active low; a fault on either phantom line alone flags it,
  // and the pin idles high through reset so no false fault is reported
  always_comb
  begin
    wire_fault_n_d = ~(fault_a_i | fault_b_i);
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      wire_fault_n_q <= 1'h1;
    else
      wire_fault_n_q <= wire_fault_n_d;
  end

  always_comb
  begin
    rd_d                             = 16'h0000;
    rd_d[acw_pkg::BIT_TYPE_A]        = net_type_pin_a_i;
    rd_d[acw_pkg::BIT_TYPE_B]        = net_type_pin_b_i;
    rd_d[acw_pkg::BIT_HOLD_ACK]      = ack_q;
    rd_d[acw_pkg::BIT_DIR]           = pdma_dir_i;
    rd_d[acw_pkg::BIT_REQ_VIEW]      = pdma_req_i;
    rd_d[acw_pkg::BIT_PDMA_EN]       = pdma_en_q;
    rd_d[acw_pkg::BIT_HOLD_RST]      = hold_q;
    rd_d[11:9]                       = plain_rd;
    rd_d[acw_pkg::BIT_IRQ_EN]        = irq_en_q;
    rd_d[acw_pkg::BIT_PARITY]        = par_q;
    rd_d[acw_pkg::BIT_NSEL_A]        = nsel_q[0];
    rd_d[acw_pkg::BIT_NSEL_B]        = nsel_q[1];
  end

  // Read word is registered: the host sees a change one edge late, traded
  // for a port with no combinational path from the live pins
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rd_q <= acw_pkg::RST_RD_WORD;
    else
      rd_q <= rd_d;
  end

  // Select pins come straight from the store; frozen outside hold reset
  assign net_select_out_a_o    = nsel_q[0];
  assign net_select_out_b_o    = nsel_q[1];
  assign core_reset_o          = hold_q;
  assign parity_check_enable_o = par_q;
  assign host_irq_out_o        = irq_q;
  assign pdma_active_o         = act_q;
  assign low_speed_mode_o      = low_q;
  assign wire_fault_n_o        = wire_fault_n_q;
  assign rd_data_o             = rd_q;

endmodule

// file: testbench/acw_ctrl_sva.sv
/* Port checker for acw_ctrl.
   Assumes it is bound onto every acw_ctrl instance. */
`timescale 1ns/1ps
module acw_ctrl_chk (
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  input wire logic        wr_en_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [15:0] rd_data_o,
  input wire logic        sys_irq_i,
  input wire logic        pdma_req_i,
  input wire logic        fault_a_i,
  input wire logic        fault_b_i,
  input wire logic        host_irq_out_o,
  input wire logic        pdma_active_o,
  input wire logic        parity_check_enable_o,
  input wire logic        net_select_out_a_o,
  input wire logic        net_select_out_b_o,
  input wire logic        low_speed_mode_o,
  input wire logic        core_reset_o,
  input wire logic        wire_fault_n_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic [1:0] sel = {net_select_out_b_o, net_select_out_a_o};
  a_irq_gate: assert property (##1 host_irq_out_o ==
    (rd_data_o[7] & rd_data_o[6] & !rd_data_o[4] | rd_data_o[12] & $past(sys_irq_i)))
    else $error("host irq gating wrong");
  a_pdma_act: assert property (pdma_active_o ==
    (rd_data_o[7] & rd_data_o[6] & rd_data_o[4])) else $error("pdma active wrong");
  a_irq_off: assert property (!rd_data_o[7] & !rd_data_o[12] |->
    !host_irq_out_o) else $error("irq raised while gated");
  a_sel_lock: assert property (!(wr_en_i & core_reset_o) |=> $stable(sel))
    else $error("select changed outside hold");
  a_sel_load: assert property (wr_en_i & core_reset_o |=>
    sel == $past(wr_data_i[15:14])) else $error("select not loaded");
  a_sel_map: assert property (##1 rd_data_o[15:14] == $past(sel))
    else $error("select pins differ from word");
  a_hold_bit: assert property (##1 rd_data_o[8] == $past(core_reset_o))
    else $error("hold reset differs from word");
  a_low_spd: assert property (##1 low_speed_mode_o == $past(&sel))
    else $error("low speed decode wrong");
  a_wire_flt: assert property (##1 wire_fault_n_o == !$past(fault_a_i | fault_b_i))
    else $error("wire fault wrong");
  a_par_bit: assert property (##1 rd_data_o[13] == $past(parity_check_enable_o))
    else $error("parity enable differs from word");
  c_act: cover property (pdma_active_o);
  c_low: cover property (low_speed_mode_o);
  c_preq: cover property (host_irq_out_o & rd_data_o[7] & !rd_data_o[12]);
endmodule
bind acw_ctrl acw_ctrl_chk acw_ctrl_chk_i (.core_clk_i, .rst_b_i, .wr_en_i, .wr_data_i,
  .rd_data_o, .sys_irq_i, .pdma_req_i, .fault_a_i, .fault_b_i, .host_irq_out_o,
  .pdma_active_o, .parity_check_enable_o, .net_select_out_a_o, .net_select_out_b_o,
  .low_speed_mode_o, .core_reset_o, .wire_fault_n_o);

// file: testbench/acw_host.sv
/* Host processor model writing the control word.
   Assumes the word is taken on a rising edge with the strobe high. */
`timescale 1ns/1ps
module acw_host (
  input  wire logic        core_clk_i,
  output logic             wr_en_o,
  output logic [15:0]      wr_data_o
);
  initial wr_en_o = 1'b0;
  initial wr_data_o = 16'h0000;
  // Released data shows the inverse so a late sample cannot pass
  task automatic wr(input logic [15:0] d);
  begin
    @(negedge core_clk_i);
    wr_en_o = 1'b1;
    wr_data_o = d;
    @(negedge core_clk_i);
    wr_en_o = 1'b0;
    wr_data_o = ~d;
  end
  endtask
endmodule

// file: testbench/adapter_control_irq_pdma_test.sv
/* Self-checking bench for acw_ctrl driven by the host model.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module adapter_control_irq_pdma_test;
  logic        core_clk_i, rst_b_i, wr_en_i, sys_irq_i, pdma_req_i, pdma_dir_i;
  logic        net_type_pin_a_i, net_type_pin_b_i, fault_a_i, fault_b_i, clock_fail_i;
  logic        host_irq_out_o, pdma_active_o, parity_check_enable_o, net_select_out_a_o;
  logic        net_select_out_b_o, low_speed_mode_o, core_reset_o, wire_fault_n_o;
  logic [15:0] wr_data_i, rd_data_o;
  int          err_total = 0;
  int          n_tests = 0;
  localparam logic [15:0] SW [6] = '{16'h4000, 16'h4000, 16'hcf00, 16'h8000, 16'h6000, 16'h0000};
  // Packed as {hold, select b, select a, low speed, parity, 0}
  localparam logic [5:0]  SE [6] = '{6'h00, 6'h28, 6'h3c, 6'h10, 6'h12, 6'h10};
  acw_ctrl acw_ctrl_i (.core_clk_i, .rst_b_i, .wr_en_i, .wr_data_i, .rd_data_o, .sys_irq_i,
    .pdma_req_i, .pdma_dir_i, .net_type_pin_a_i, .net_type_pin_b_i, .fault_a_i, .fault_b_i,
    .parity_default_strap_i(1'b1), .clock_fail_i, .host_irq_out_o, .pdma_active_o,
    .parity_check_enable_o, .net_select_out_a_o, .net_select_out_b_o, .low_speed_mode_o,
    .core_reset_o, .wire_fault_n_o);
  acw_host acw_host_i (.core_clk_i, .wr_en_o(wr_en_i), .wr_data_o(wr_data_i));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
  begin
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  end
  endtask
  task automatic wrap_up;
  begin
    if (err_total == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task automatic do_reset;
  begin
    @(negedge core_clk_i);
    rst_b_i = 1'b0;
    {fault_a_i, fault_b_i} = 2'h0;
    repeat (16) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    @(negedge core_clk_i);
    chk("reset", 16'h0013, {10'h000, host_irq_out_o, core_reset_o, net_select_out_b_o,
      net_select_out_a_o, parity_check_enable_o, wire_fault_n_o});
  end
  endtask
  task automatic t_irq;
    logic [4:0] v;
    logic       ak;
  begin
    for (int i = 0; i < 32; i++)
    begin
      v = i[4:0];
      ak = v[2] & v[3];
      acw_host_i.wr({3'h0, v[4], 4'h0, v[3], 2'h0, v[2], 4'h0});
      {pdma_dir_i, pdma_req_i, sys_irq_i} = {v[0], v[1:0]};
      repeat (2) @(negedge core_clk_i);
      chk("irq", {9'h000, v[4], v[3], v[0], v[1], ak,
        v[3] & v[1] & !ak | v[4] & v[0], v[3] & v[1] & ak},
        {9'h000, rd_data_o[12], rd_data_o[7], rd_data_o[5], rd_data_o[6], rd_data_o[4],
        host_irq_out_o, pdma_active_o});
    end
  end
  endtask
  // Select writes are legal only while held, so each step leans on the previous one
  task automatic t_sel;
  begin
    for (int i = 0; i < 6; i++)
    begin
      clock_fail_i = (i == 1);
      acw_host_i.wr(SW[i]);
      clock_fail_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      chk("select", {10'h000, SE[i]}, {10'h000, core_reset_o, net_select_out_b_o,
        net_select_out_a_o, low_speed_mode_o, parity_check_enable_o, 1'b0});
      chk("word", {9'h000, SE[i][4:3], SE[i][1], SW[i][11:9], SE[i][5]},
        {9'h000, rd_data_o[15:13], rd_data_o[11:8]});
    end
  end
  endtask
  task automatic t_pins;
  begin
    for (int i = 0; i < 16; i++)
    begin
      {fault_a_i, fault_b_i, net_type_pin_a_i, net_type_pin_b_i} = i[3:0];
      repeat (2) @(negedge core_clk_i);
      chk("pins", {13'h0000, !(i[3] | i[2]), i[0], i[1]},
        {13'h0000, wire_fault_n_o, rd_data_o[2], rd_data_o[0]});
    end
  end
  endtask
  initial
  begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  initial
  begin
    #200000;
    err_total++;
    wrap_up();
  end
  initial
  begin
    {rst_b_i, sys_irq_i, pdma_req_i, pdma_dir_i, clock_fail_i} = 5'h00;
    {net_type_pin_a_i, net_type_pin_b_i, fault_a_i, fault_b_i} = 4'h0;
    do_reset();
    t_irq();
    t_sel();
    t_pins();
    do_reset();
    wrap_up();
  end
endmodule
